// ---- rtl/fsr_defines.svh ----
// Constants for the flash status and read command block.
// Summary of operation
// - Opcode 04h clears the write enable latch.
// - Latch clears at power-up and write completion.
// - Status reads use 05h, 35h, 15h.
// - Status byte out on falling edges, MSB first.
// - Status reads accepted even while busy.
// - Status byte repeats until select rises.
// - Status writes 01h/31h/11h touch writable bits only.
// - Security lock bits are one-time programmable.
// - Non-volatile write needs 06h and latch set.
// - Volatile write needs 50h just before.
// - Volatile write keeps lock bits set.
// - Resets reload status from non-volatile copy.
// - Non-volatile write runs timed busy, clears latch.
// - Volatile write lands fast, busy stays low.
// - Quad enable frozen in quad command mode.
// - 01h with two bytes writes registers one, two.
// - Read takes 03h and 24-bit address, MSB first.
// - Read data follows address, no dummy cycles.
// - Read address increments, stream until select rises.
// - Read ignored while busy.
// - Read only in single-lane mode.
// - Opcode 06h sets the write enable latch.
`ifndef FSR_DEFINES_SVH
`define FSR_DEFINES_SVH
// Instruction codes.
`define FSR_OP_WREN   8'h06
`define FSR_OP_WRDI   8'h04
`define FSR_OP_VWREN  8'h50
`define FSR_OP_RDSR1  8'h05
`define FSR_OP_RDSR2  8'h35
`define FSR_OP_RDSR3  8'h15
`define FSR_OP_WRSR1  8'h01
`define FSR_OP_WRSR2  8'h31
`define FSR_OP_WRSR3  8'h11
`define FSR_OP_READ   8'h03
// Bit counts that mark instruction phases on the link.
`define FSR_OPC_LAST  6'h07
`define FSR_ADR_LAST  6'h1F
`define FSR_BITS_OPC  6'h08
`define FSR_BITS_ONE  6'h10
`define FSR_BITS_TWO  6'h18
`define FSR_D1_LAST   6'h0F
`define FSR_D2_LAST   6'h17
// Field positions.
`define FSR_SR1_BUSY  0
`define FSR_SR1_WEL   1
`define FSR_SR2_PROTECT_MODE_BIT_HIGH  0
`define FSR_SR2_QE    1
`define FSR_SR2_LB_LO 3
`define FSR_SR2_LB_HI 5
// Writable masks and non-volatile reset values.
`define FSR_SR1_WMASK 8'hFC
`define FSR_SR2_WMASK 8'h7B
`define FSR_SR3_WMASK 8'hE3
`define FSR_SR1_RST   8'h00
`define FSR_SR2_RST   8'h00
`define FSR_SR3_RST   8'h00
// Timing.
`define FSR_CLK_NS          5
`define FSR_NV_WRITE_NS     10000000
`define FSR_VOL_REFRESH_NS  50
`define FSR_NV_WRITE_CYC \
    ((`FSR_NV_WRITE_NS + `FSR_CLK_NS - 1) / `FSR_CLK_NS)
`define FSR_VOL_REFRESH_CYC (`FSR_VOL_REFRESH_NS / `FSR_CLK_NS)
`endif

// ---- rtl/fsr_pkg.sv ----
// Types shared by the flash status and read command block.
package fsr_pkg;
    // One-hot states of the status write engine.
    typedef enum logic [1:0] {
        WS_IDLE = 2'b01,
        WS_NVWR = 2'b10
    } fsr_wstate_type;
    // Index of a status register.
    typedef logic [1:0] fsr_idx_type;
endpackage

// ---- rtl/fsr_array_rom.sv ----
// Read-only data array with a registered read port.
`timescale 1ns/1ps
module fsr_array_rom #(
    parameter int ADDR_W = 24
) (
    // Clock.
    input  wire logic        clk,
    // Read port.
    input  wire logic [23:0] addr,
    output logic      [7:0]  rdata
);
    // Bits above the array size fold back onto it.
    logic [23:0] a_fold;
    assign a_fold = addr & 24'((25'h1 << ADDR_W) - 25'h1);

    // The content is a fixed pattern of the address, so every byte is
    // predictable for a checker without a preload path.
    always_ff @(posedge clk) begin
        rdata <= a_fold[7:0] ^ a_fold[15:8] ^ a_fold[23:16] ^ 8'hA5;
    end
endmodule // fsr_array_rom

// ---- rtl/fsr_core.sv ----
// Serial flash status register and read data command handling.
`timescale 1ns/1ps
`include "fsr_defines.svh"
module fsr_core #(
    parameter int unsigned NV_WRITE_CYC = `FSR_NV_WRITE_CYC,
    parameter int          ARRAY_ADDR_W = 24
) (
    // System clock and reset.
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Serial link from the host.
    input  wire logic       spi_clk,
    input  wire logic       cs_n,
    input  wire logic       serial_input,
    output logic            sdo,
    output logic            sdo_oe,
    // Device pins and mode.
    input  wire logic       reset_pin_n,
    input  wire logic       quad_command_mode,
    // Status view.
    output logic            busy,
    output logic            write_enable_latch,
    output logic      [7:0] status_one,
    output logic      [7:0] status_two,
    output logic      [7:0] status_three
);
    localparam int VOL_CYC = `FSR_VOL_REFRESH_CYC;

    // Maps a status opcode to its register index; 3 means none.
    function automatic fsr_pkg::fsr_idx_type fsr_sel(input logic [7:0] op);
        unique case (op)
            `FSR_OP_RDSR1, `FSR_OP_WRSR1: return 2'h0;
            `FSR_OP_RDSR2, `FSR_OP_WRSR2: return 2'h1;
            `FSR_OP_RDSR3, `FSR_OP_WRSR3: return 2'h2;
            default:                      return 2'h3;
        endcase
    endfunction

    // True for the three status read opcodes.
    function automatic logic fsr_is_rd(input logic [7:0] op);
        return (op == `FSR_OP_RDSR1) || (op == `FSR_OP_RDSR2) ||
               (op == `FSR_OP_RDSR3);
    endfunction

    // Merges written data into a register, keeping protected bits.
    function automatic logic [7:0] fsr_merge(
        input fsr_pkg::fsr_idx_type k,
        input logic [7:0] old,
        input logic [7:0] d,
        input logic       vol,
        input logic       quad);
        logic [7:0] m;
        logic [7:0] r;
        m = (k == 2'h0) ? `FSR_SR1_WMASK :
            (k == 2'h1) ? `FSR_SR2_WMASK : `FSR_SR3_WMASK;
        r = (old & ~m) | (d & m);
        if (k == 2'h1) begin
            // Lock bits only ever rise.
            r[`FSR_SR2_LB_HI:`FSR_SR2_LB_LO] =
                r[`FSR_SR2_LB_HI:`FSR_SR2_LB_LO] |
                old[`FSR_SR2_LB_HI:`FSR_SR2_LB_LO];
            if (vol) begin
                r[`FSR_SR2_PROTECT_MODE_BIT_HIGH] = r[`FSR_SR2_PROTECT_MODE_BIT_HIGH] |
                                   old[`FSR_SR2_PROTECT_MODE_BIT_HIGH];
            end
            if (quad) begin
                r[`FSR_SR2_QE] = old[`FSR_SR2_QE];
            end
        end
        return r;
    endfunction

    // ---------------- Link domain, rising edge ----------------
    logic [5:0]  cnt_r;      // Bits taken in this frame, saturating.
    logic [5:0]  cnt_nxt;    // Next bit count.
    logic [23:0] sh_r;       // Incoming bit history.
    logic [7:0]  byte_in;    // Byte completed by the current bit.
    logic [7:0]  op_r;       // Opcode of this frame.
    logic        out_en_r;   // Device drives the serial output.
    logic        is_read_r;  // Output comes from the array.
    logic [23:0] rd_addr_r;  // Array address of the next byte.
    logic [23:0] mem_addr;   // Address presented to the array.
    logic [7:0]  rdata;      // Array read data.
    logic [5:0]  cap_n_r;    // Frame length, held after the frame.
    logic [7:0]  cap_op_r;   // Frame opcode, held after the frame.
    logic [7:0]  cap_d1_r;   // First data byte, held.
    logic [7:0]  cap_d2_r;   // Second data byte, held.
    // Link negative edge.
    logic [2:0]  obit_r;     // Bit position of the output byte.
    logic [7:0]  osh_r;      // Output shift register.
    logic [7:0]  ld_byte;    // Byte to start sending.
    // Snapshots from the system domain, frozen while selected.
    logic [7:0]  snap1_r;
    logic [7:0]  snap2_r;
    logic [7:0]  snap3_r;
    logic        snapq_r;

    assign byte_in = {sh_r[6:0], serial_input};
    assign cnt_nxt = (cnt_r == 6'h3F) ? cnt_r : cnt_r + 6'h01;

    // Bit counter and shift history; a high select ends the frame.
    always_ff @(posedge spi_clk or posedge cs_n) begin
        if (cs_n) begin
            cnt_r <= 6'h00;
            sh_r  <= 24'h000000;
        end else begin
            cnt_r <= cnt_nxt;
            sh_r  <= {sh_r[22:0], serial_input};
        end
    end

    // Opcode capture and start of output.
    always_ff @(posedge spi_clk or posedge cs_n) begin
        if (cs_n) begin
            op_r      <= 8'h00;
            out_en_r  <= 1'b0;
            is_read_r <= 1'b0;
        end else if (cnt_r == `FSR_OPC_LAST) begin
            op_r     <= byte_in;
            out_en_r <= fsr_is_rd(byte_in);
        end else if (cnt_r == `FSR_ADR_LAST && op_r == `FSR_OP_READ &&
                     !snap1_r[`FSR_SR1_BUSY] && !snapq_r) begin
            // A read during busy or quad mode never starts.
            out_en_r  <= 1'b1;
            is_read_r <= 1'b1;
        end
    end

    // Read address: loaded from the last address bit, then stepped
    // on the rising edge after each byte has been loaded.
    always_ff @(posedge spi_clk or posedge cs_n) begin
        if (cs_n) begin
            rd_addr_r <= 24'h000000;
        end else if (cnt_r == `FSR_ADR_LAST) begin
            rd_addr_r <= {sh_r[22:0], serial_input};
        end else if (is_read_r && obit_r == 3'h1) begin
            rd_addr_r <= rd_addr_r + 24'h000001;
        end
    end

    // The first byte is fetched on the edge of the last address bit.
    assign mem_addr = (cnt_r == `FSR_ADR_LAST) ?
                      {sh_r[22:0], serial_input} : rd_addr_r;

    fsr_array_rom #(
        .ADDR_W (ARRAY_ADDR_W)
    ) u_rom (
        .clk   (spi_clk),
        .addr  (mem_addr),
        .rdata (rdata)
    );

    // Frame results stay put once the clock stops, so the system side
    // can read them after it sees select high. No reset is needed:
    // they are only read after a frame has written them.
    always_ff @(posedge spi_clk) begin
        cap_n_r <= cnt_nxt;
        if (cnt_r == `FSR_OPC_LAST) begin
            cap_op_r <= byte_in;
        end
        if (cnt_r == `FSR_D1_LAST) begin
            cap_d1_r <= byte_in;
        end
        if (cnt_r == `FSR_D2_LAST) begin
            cap_d2_r <= byte_in;
        end
    end

    // Selects the byte to send next.
    always_comb begin
        unique case (fsr_sel(op_r))
            2'h0:    ld_byte = snap1_r;
            2'h1:    ld_byte = snap2_r;
            default: ld_byte = snap3_r;
        endcase
        if (is_read_r) begin
            ld_byte = rdata;
        end
    end

    // Output shifter on the falling edge, MSB first; the status byte
    // reloads every eight bits, so it repeats.
    always_ff @(negedge spi_clk or posedge cs_n) begin
        if (cs_n) begin
            obit_r <= 3'h0;
            osh_r  <= 8'h00;
            sdo    <= 1'b0;
        end else if (out_en_r) begin
            obit_r <= obit_r + 3'h1;
            if (obit_r == 3'h0) begin
                sdo   <= ld_byte[7];
                osh_r <= {ld_byte[6:0], 1'b0};
            end else begin
                sdo   <= osh_r[7];
                osh_r <= {osh_r[6:0], 1'b0};
            end
        end
    end
    assign sdo_oe = out_en_r;

    // ---------------- System domain ----------------
    logic [1:0] s1_r;   // Synchroniser stage one: cs_n, reset pin.
    logic [1:0] s2_r;
    logic [1:0] s3_r;
    logic [1:0] q_r;    // Filtered pin levels.
    logic       fe;     // Frame end seen.
    logic       pin_act; // Reset pin held.
    fsr_pkg::fsr_wstate_type st_r;
    logic [31:0] tmr_r;  // Remaining busy cycles.
    logic       done;    // Last busy cycle.
    logic       wel_r;
    logic       vwe_r;   // Volatile write armed.
    logic [7:0] vol_r [3];
    logic [7:0] nv_r  [3];
    logic [7:0] pend_r [3];
    logic [7:0] wnew  [3];
    logic       ok8;
    logic       wren_ev;
    logic       wrdi_ev;
    logic       wrsr_ev;
    logic       vol_ev;
    logic       nv_ev;
    logic       two;

    // Three-stage synchronisers; a change counts once stages two and
    // three agree.
    for (genvar g = 0; g < 2; g++) begin : g_sync
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                s1_r[g] <= 1'b1;
                s2_r[g] <= 1'b1;
                s3_r[g] <= 1'b1;
                q_r[g]  <= 1'b1;
            end else begin
                s1_r[g] <= (g == 0) ? cs_n : reset_pin_n;
                s2_r[g] <= s1_r[g];
                s3_r[g] <= s2_r[g];
                if (s2_r[g] == s3_r[g]) begin
                    q_r[g] <= s3_r[g];
                end
            end
        end
    end

    assign fe      = !q_r[0] && s2_r[0] && s3_r[0];
    assign pin_act = !q_r[1];
    assign busy    = st_r[1];
    assign done    = busy && (tmr_r == 32'h0);

    // Frame decode; single-byte commands need exactly one byte.
    assign ok8     = fe && (cap_n_r == `FSR_BITS_OPC);
    assign wren_ev = ok8 && cap_op_r == `FSR_OP_WREN && !busy;
    assign wrdi_ev = ok8 && cap_op_r == `FSR_OP_WRDI && !busy;
    assign wrsr_ev = fe && !busy && fsr_sel(cap_op_r) != 2'h3 &&
                     !fsr_is_rd(cap_op_r) &&
                     cap_n_r >= `FSR_BITS_ONE;
    assign vol_ev  = wrsr_ev && vwe_r;
    assign nv_ev   = wrsr_ev && !vwe_r && wel_r;
    assign two     = cap_op_r == `FSR_OP_WRSR1 &&
                     cap_n_r >= `FSR_BITS_TWO;

    // New register values for a status write.
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            if (fsr_sel(cap_op_r) == 2'(k) || (two && k == 1)) begin
                wnew[k] = fsr_merge(2'(k), vwe_r ? vol_r[k] : nv_r[k],
                                    (two && k == 1) ? cap_d2_r : cap_d1_r,
                                    vwe_r, quad_command_mode);
            end else begin
                wnew[k] = vwe_r ? vol_r[k] : nv_r[k];
            end
        end
    end

    // Self-timed non-volatile write cycle.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r  <= fsr_pkg::WS_IDLE;
            tmr_r <= 32'h0;
        end else begin
            unique case (st_r)
                fsr_pkg::WS_IDLE: begin
                    if (nv_ev) begin
                        st_r  <= fsr_pkg::WS_NVWR;
                        tmr_r <= NV_WRITE_CYC - 32'h1;
                    end
                end
                fsr_pkg::WS_NVWR: begin
                    if (done) begin
                        st_r <= fsr_pkg::WS_IDLE;
                    end else begin
                        tmr_r <= tmr_r - 32'h1;
                    end
                end
                default: st_r <= fsr_pkg::WS_IDLE;
            endcase
        end
    end

    // Write enable latch and volatile write arm. Any other frame end
    // disarms the volatile enable, so it must come just before.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wel_r <= 1'b0;
            vwe_r <= 1'b0;
        end else if (pin_act || done) begin
            wel_r <= 1'b0;
            vwe_r <= 1'b0;
        end else begin
            if (wren_ev) begin
                wel_r <= 1'b1;
            end else if (wrdi_ev) begin
                wel_r <= 1'b0;
            end
            if (fe) begin
                vwe_r <= ok8 && cap_op_r == `FSR_OP_VWREN;
            end
        end
    end

    // Status copies: volatile values follow resets from the
    // non-volatile ones; the pending set lands when busy ends.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            nv_r[0]  <= `FSR_SR1_RST;
            nv_r[1]  <= `FSR_SR2_RST;
            nv_r[2]  <= `FSR_SR3_RST;
            vol_r[0] <= `FSR_SR1_RST;
            vol_r[1] <= `FSR_SR2_RST;
            vol_r[2] <= `FSR_SR3_RST;
            pend_r   <= '{default: 8'h00};
        end else begin
            if (nv_ev) begin
                pend_r <= wnew;
            end
            if (done) begin
                nv_r  <= pend_r;
                vol_r <= pend_r;
            end else if (pin_act) begin
                vol_r <= nv_r;
            end else if (vol_ev) begin
                vol_r <= wnew;
            end
        end
    end

    // Snapshot for the link, refreshed only while deselected so the
    // link never sees a word change mid-frame.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            snap1_r <= 8'h00;
            snap2_r <= 8'h00;
            snap3_r <= 8'h00;
            snapq_r <= 1'b0;
        end else if (q_r[0]) begin
            snap1_r <= {vol_r[0][7:2], wel_r, busy};
            snap2_r <= vol_r[1];
            snap3_r <= vol_r[2];
            snapq_r <= quad_command_mode;
        end
    end

    assign write_enable_latch = wel_r;
    assign status_one   = {vol_r[0][7:2], wel_r, busy};
    assign status_two   = vol_r[1];
    assign status_three = vol_r[2];

    // ---------------- Checks ----------------
    AST_READ_BUSY: assert property (@(posedge spi_clk) disable iff (cs_n)
        (cnt_r == `FSR_ADR_LAST && op_r == `FSR_OP_READ &&
         snap1_r[0]) |=> !out_en_r)
        else $error("Read started while busy.");
    AST_READ_QUAD: assert property (@(posedge spi_clk) disable iff (cs_n)
        (cnt_r == `FSR_ADR_LAST && snapq_r) |=> !is_read_r)
        else $error("Read started in quad mode.");
    AST_ADDR_STEP: assert property (@(posedge spi_clk) disable iff (cs_n)
        (is_read_r && obit_r == 3'h1) |=>
        rd_addr_r == 24'($past(rd_addr_r) + 24'h1))
        else $error("Read address did not step.");
    AST_RDSR_START: assert property (@(posedge spi_clk) disable iff (cs_n)
        (cnt_r == `FSR_OPC_LAST && fsr_is_rd(byte_in)) |=>
        out_en_r && !is_read_r)
        else $error("Status read not started.");
    AST_FIRST_BIT: assert property (@(negedge spi_clk) disable iff (cs_n)
        (out_en_r && obit_r == 3'h0 && !is_read_r &&
         op_r == `FSR_OP_RDSR2) |=> sdo == snap2_r[7] ##1
        sdo == snap2_r[6])
        else $error("Status byte not sent MSB first.");
    AST_WRDI: assert property (@(posedge sys_clk) disable iff (rst)
        (wrdi_ev && !wren_ev) |=> !wel_r)
        else $error("Write disable left latch set.");
    AST_WREN: assert property (@(posedge sys_clk) disable iff (rst)
        (wren_ev && !pin_act) |=> wel_r ##1 wel_r)
        else $error("Write enable did not set latch.");
    AST_NV_START: assert property (@(posedge sys_clk) disable iff (rst)
        nv_ev |=> busy && !done[*1])
        else $error("Non-volatile write did not raise busy.");
    AST_NV_END: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(busy) |-> !wel_r && nv_r[1] == $past(pend_r[1]))
        else $error("Busy ended without clearing latch.");
    AST_VOL: assert property (@(posedge sys_clk) disable iff (rst)
        (vol_ev && !pin_act) |=>
        (vol_r[0] == $past(wnew[0]) && vol_r[1] == $past(wnew[1]) &&
         !busy && !wel_r))
        else $error("Volatile write missing or set busy.");
    AST_OTP: assert property (@(posedge sys_clk)
        disable iff (rst || pin_act)
        ($past(vol_r[1][5:3]) & ~vol_r[1][5:3]) == 3'h0)
        else $error("Lock bit cleared.");
    AST_QE: assert property (@(posedge sys_clk) disable iff (rst)
        (vol_ev && quad_command_mode && !pin_act) |=>
        $stable(vol_r[1][`FSR_SR2_QE]))
        else $error("Quad enable written in quad mode.");
    AST_SR2_SHORT: assert property (@(posedge sys_clk) disable iff (rst)
        (vol_ev && cap_op_r == `FSR_OP_WRSR1 && !two && !pin_act) |=>
        $stable(vol_r[1]))
        else $error("Short write changed register two.");
endmodule // fsr_core

// ---- testbench/fsr_host_model.sv ----
// Host serial controller model that drives frames into the flash block.
`timescale 1ns/1ps
module fsr_host_model (
    // Serial link toward the device.
    output logic      spi_clk,
    output logic      cs_n,
    output logic      serial_input,
    // Device answer.
    input  wire logic sdo,
    input  wire logic sdo_oe
);
    // Deselected link with the clock parked low; it never runs free.
    initial begin
        spi_clk      = 1'b0;
        cs_n         = 1'b1;
        serial_input = 1'b1;
    end

    // One frame at a 6 ns bit time: ntx bits MSB first, then nrx answer
    // bits. Data changes while the clock is low, answers are taken on the
    // rising edge, and the frame is closed with no extra bits.
    task automatic frame(input logic [39:0] tx, input int ntx,
                         input int nrx, output logic [39:0] rx,
                         output logic oe);
        rx   = '0;
        oe   = 1'b0;
        cs_n = 1'b0;
        for (int i = 0; i < ntx + nrx; i++) begin
            // Past the request the line toggles, so no stale bit lingers.
            serial_input = (i < ntx) ? tx[39 - i] : ~serial_input;
            #3 spi_clk = 1'b1;
            if (i >= ntx) begin
                rx = {rx[38:0], sdo};
            end
            oe = oe | sdo_oe;
            #3 spi_clk = 1'b0;
        end
        #3 cs_n = 1'b1;
        serial_input = ~serial_input;
        // Deselect gap of six system cycles, one above the five the block needs.
        #30;
    endtask
endmodule // fsr_host_model

// ---- testbench/fsr_core_tb.sv ----
// Self-checking bench for the flash status and read command block.
`timescale 1ns/1ps
module fsr_core_tb;
    // Short write cycle so the busy window stays brief in simulation.
    localparam int unsigned NVC = 200;
    logic        sys_clk, rst, spi_clk, cs_n, serial_input, sdo, sdo_oe;
    logic        reset_pin_n, quad_command_mode, busy, write_enable_latch;
    logic [7:0]  status_one, status_two, status_three, d, e, got_v;
    logic [7:0]  exp_q[$];
    logic [23:0] a;
    logic [39:0] rx;
    logic        oe;
    event        got_ev;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          seed = 32'hb2b7694b;

    fsr_core #(.NV_WRITE_CYC(NVC)) fsr_core_i (.sys_clk(sys_clk), .rst(rst),
        .spi_clk(spi_clk), .cs_n(cs_n), .serial_input(serial_input),
        .sdo(sdo), .sdo_oe(sdo_oe), .reset_pin_n(reset_pin_n),
        .quad_command_mode(quad_command_mode), .busy(busy),
        .write_enable_latch(write_enable_latch), .status_one(status_one),
        .status_two(status_two), .status_three(status_three));
    fsr_host_model fsr_host_model_i (.spi_clk(spi_clk), .cs_n(cs_n),
        .serial_input(serial_input), .sdo(sdo), .sdo_oe(sdo_oe));

    // System clock at 200 MHz.
    initial sys_clk = 1'b0;
    always #2.5 sys_clk = ~sys_clk;

    // Compares one value and counts the outcome.
    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Plain frame with no answer expected.
    task automatic send(input logic [39:0] tx, input int n);
        fsr_host_model_i.frame(tx, n, 0, rx, oe);
    endtask

    // Frame whose nb answer bytes are handed one by one to the monitor.
    task automatic xfer(input logic [39:0] tx, input int n, input int nb);
        fsr_host_model_i.frame(tx, n, 8 * nb, rx, oe);
        for (int k = 0; k < nb; k++) begin
            got_v = rx[8 * (nb - 1 - k) +: 8];
            -> got_ev;
            #1;
        end
    endtask

    // Array content seen through the read port.
    function automatic logic [7:0] arr(input logic [23:0] x);
        return x[7:0] ^ x[15:8] ^ x[23:16] ^ 8'hA5;
    endfunction

    // Monitor: each answer byte is matched against the oldest note.
    always begin
        @(got_ev);
        check(got_v, exp_q.pop_front());
    end

    task automatic print_verdict;
        $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under this span.
    initial begin
        #300000;
        error_cnt++;
        print_verdict();
    end

    initial begin
        rst = 1'b1;
        reset_pin_n = 1'b1;
        quad_command_mode = 1'b0;
        repeat (20) @(negedge sys_clk);
        rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        // Every status byte reads zero after power-up and repeats.
        exp_q.delete();
        for (int k = 0; k < 3; k++) begin
            exp_q.push_back(8'h00);
            exp_q.push_back(8'h00);
            xfer({k == 0 ? 8'h05 : k == 1 ? 8'h35 : 8'h15, 32'h0}, 8, 2);
        end
        send({8'h06, 32'h0}, 8);
        check(write_enable_latch, 1'b1);
        exp_q.push_back(8'h02);
        exp_q.push_back(8'h02);
        xfer({8'h05, 32'h0}, 8, 2);
        send({8'h04, 32'h0}, 8);
        check(write_enable_latch, 1'b0);
        // A lasting write without the latch set is refused.
        d = $random(seed);
        send({8'h01, d, 24'h0}, 16);
        check(status_one, 8'h00);
        send({8'h06, 32'h0}, 8);
        send({8'h01, d, 24'h0}, 16);
        check(busy, 1'b1);
        // Polling works while busy; a read is refused meanwhile.
        exp_q.push_back(8'h03);
        xfer({8'h05, 32'h0}, 8, 1);
        a = $random(seed);
        fsr_host_model_i.frame({8'h03, a, 8'h0}, 32, 8, rx, oe);
        check(oe, 1'b0);
        for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge sys_clk);
        check({busy, write_enable_latch}, 2'b00);
        check(status_one, d & 8'hFC);
        // Quick writes: locks stick, busy stays low, two-byte form.
        send({8'h50, 32'h0}, 8);
        send({8'h31, 8'h38, 24'h0}, 16);
        check({busy, write_enable_latch, status_two}, {2'b00, 8'h38});
        send({8'h50, 32'h0}, 8);
        send({8'h31, 8'h00, 24'h0}, 16);
        check(status_two, 8'h38);
        e = $random(seed);
        d = $random(seed);
        send({8'h50, 32'h0}, 8);
        send({8'h01, e, d, 16'h0}, 24);
        check({status_one, status_two}, {e & 8'hFC, d & 8'h7B | 8'h38});
        send({8'h50, 32'h0}, 8);
        send({8'h11, 8'hFF, 24'h0}, 12);
        check(status_three, 8'h00);
        send({8'h50, 32'h0}, 8);
        send({8'h11, 8'hFF, 24'h0}, 16);
        check(status_three, 8'hE3);
        // Reset pin drops quick values and restores the lasting ones.
        @(negedge sys_clk) reset_pin_n = 1'b0;
        repeat (6) @(negedge sys_clk);
        reset_pin_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        check({status_two, status_three}, 16'h0000);
        // Quad command mode freezes the quad bit and refuses reads.
        quad_command_mode = 1'b1;
        repeat (4) @(negedge sys_clk);
        send({8'h50, 32'h0}, 8);
        send({8'h31, 8'h02, 24'h0}, 16);
        check(status_two, 8'h00);
        fsr_host_model_i.frame({8'h03, a, 8'h0}, 32, 8, rx, oe);
        check(oe, 1'b0);
        @(negedge sys_clk) quad_command_mode = 1'b0;
        repeat (4) @(negedge sys_clk);
        // Streamed read across a byte carry in the address.
        a[7:0] = 8'hFF;
        exp_q.push_back(arr(a));
        exp_q.push_back(arr(a + 24'h1));
        xfer({8'h03, a, 8'h0}, 32, 2);
        check(exp_q.size(), 0);
        print_verdict();
    end
endmodule // fsr_core_tb
